// [verilog/fpc_pkg.sv]
// Purpose: Shared constants and types for the fan PWM and conversion timing block.
// Assumes: 125 MHz system clock; 8-bit register address and data.
// Notes: Time figures are kept in their own units; cycle counts derive from them.
`default_nettype none

package fpc_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_CONV_RATE = 8'h04;
    localparam logic [7:0] ADDR_CONV_RATE_WR = 8'h0A;
    localparam logic [7:0] ADDR_ONE_SHOT = 8'h0F;
    localparam logic [7:0] ADDR_ENH_CFG = 8'h45;
    localparam logic [7:0] ADDR_PWM_CFG = 8'h4A;
    localparam logic [7:0] ADDR_PWM_DUTY = 8'h4C;
    localparam logic [7:0] ADDR_PWM_FREQ = 8'h4D;
    localparam logic [7:0] ADDR_RUN_CTRL = 8'h50;
    localparam logic [7:0] ADDR_STATUS = 8'h51;
    localparam logic [7:0] ADDR_MAKER_ID = 8'hFE;
    localparam logic [7:0] ADDR_DIE_REV = 8'hFF;

    // Field positions
    localparam int HRES_BIT = 4;
    localparam int PWM_CLK_BIT = 3;
    localparam int STANDBY_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_PWM_BIT = 1;

    // Reset values
    localparam logic [3:0] CONV_RATE_RST = 4'h8;
    localparam logic [4:0] PWM_FREQ_RST = 5'h08;
    localparam logic [7:0] PWM_DUTY_RST = 8'h00;

    // Conversion rate codes and periods in microseconds
    localparam logic [3:0] CONV_CODE_MAX = 4'h9;
    localparam int unsigned RATE_PERIOD_US [0:9] = '{
        20000000, 10000000, 4901961, 2463054, 1230012,
        615385, 307692, 153846, 76923, 38462
    };
    localparam int unsigned CONV_TIME_US = 1000;

    // Clocking
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned CLK_PER_US = CLK_HZ / 1000000;
    localparam int unsigned PWM_FAST_HZ = 360000;
    localparam int unsigned FAST_PER_HR = 16;
    localparam int unsigned SLOW_PER_FAST = 256;
    localparam int unsigned HR_STEP_HZ = PWM_FAST_HZ * FAST_PER_HR;
    localparam int unsigned HR_DIV = CLK_HZ / HR_STEP_HZ;

    // PWM encoding
    localparam logic [4:0] HR_FREQ_CODE = 5'h08;
    localparam logic [7:0] HR_PERIOD_TOP = 8'hFE;
    localparam int TIME_W = 26;

    typedef enum logic [1:0] {
        FSM_IDLE = 2'b01,
        FSM_CONV = 2'b10
    } fpc_fsm_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fpc_bus_t;

    typedef struct packed {
        logic hr;
        logic fast;
        logic slow;
    } fpc_ticks_t;

    typedef struct packed {
        logic [15:0] hrCnt;
        logic [3:0] fastCnt;
        logic [7:0] slowCnt;
        fpc_ticks_t ticks;
    } fpc_tick_state_t;

    typedef struct packed {
        logic [3:0] convCode;
        logic [4:0] pwmFreq;
        logic [7:0] pwmDuty;
        logic hrSel;
        logic clkSel;
        logic standby;
        logic pending;
        fpc_fsm_t fsm;
        logic [15:0] usCnt;
        logic [TIME_W-1:0] periodCnt;
        logic [TIME_W-1:0] convCnt;
        logic [7:0] stepCnt;
        logic pwmOut;
        logic convStart;
        logic [7:0] rdData;
    } fpc_state_t;

endpackage : fpc_pkg

`default_nettype wire

// [verilog/fpc_tick_gen.sv]
// Purpose: Step ticks for the PWM: high-resolution, fast and slow internal clocks.
// Assumes: Ticks are one-cycle pulses of the system clock.
// Notes: Fast tick is one in sixteen high-resolution ticks; slow is fast over 256.
`default_nettype none

module fpc_tick_gen
    import fpc_pkg::*;
#(
    parameter int unsigned DIV = HR_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Ticks
    output fpc_ticks_t ticks
);

    fpc_tick_state_t s_q;
    fpc_tick_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.ticks = '0;
        if (s_q.hrCnt == 16'(DIV - 1)) begin
            s_d.hrCnt = '0;
            s_d.ticks.hr = 1'b1;
            s_d.fastCnt = s_q.fastCnt + 4'h1;
            if (s_q.fastCnt == 4'(FAST_PER_HR - 1)) begin
                s_d.ticks.fast = 1'b1;
                s_d.slowCnt = s_q.slowCnt + 8'h01;
                s_d.ticks.slow = (s_q.slowCnt == 8'(SLOW_PER_FAST - 1));
            end
        end else begin
            s_d.hrCnt = s_q.hrCnt + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ticks = s_q.ticks;

endmodule : fpc_tick_gen

`default_nettype wire

// [verilog/fpc_top.sv]
// Purpose: Fan PWM generator with conversion scheduling and identification registers.
// Assumes: Register port strobes are one cycle; read data stand one cycle after the read.
// Notes: Conversion timing runs on a microsecond tick; counts scale down by parameters.
`default_nettype none

module fpc_top
    import fpc_pkg::*;
#(
    parameter int unsigned CYCLES_PER_US = CLK_PER_US,
    parameter int unsigned PERIOD_DIV = 1,
    parameter int unsigned CONV_US = CONV_TIME_US,
    parameter int unsigned TICK_DIV = HR_DIV,
    // Arbitrary identification values
    parameter logic [7:0] MAKER_CODE = 8'h5A,
    parameter logic [7:0] DIE_REV_CODE = 8'h23
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire fpc_bus_t bus,
    output logic [7:0] rdData,
    // Fan drive
    output logic pwmOut,
    // Conversion scheduling
    output logic convStart,
    output logic convBusy
);

    fpc_state_t s_q;
    fpc_state_t s_d;
    fpc_ticks_t ticks;

    fpc_tick_gen #(
        .DIV(TICK_DIV)
    ) u_ticks (
        .clk(clk),
        .reset(reset),
        .ticks(ticks)
    );

    // Conversion period in microseconds for a rate code
    function automatic logic [TIME_W-1:0] rate_period(input logic [3:0] code);
        logic [3:0] idx;
        logic [TIME_W-1:0] lim;
        idx = (code > CONV_CODE_MAX) ? CONV_CODE_MAX : code;
        lim = TIME_W'(RATE_PERIOD_US[idx]) / TIME_W'(PERIOD_DIV);
        if (lim == '0) begin
            lim = TIME_W'(1);
        end
        return lim;
    endfunction : rate_period

    logic usTick;
    logic periodic;
    logic hires;
    logic stepTick;
    logic [4:0] freqEff;
    logic [7:0] periodTop;
    logic pwmHigh;

    always_comb begin
        s_d = s_q;
        s_d.convStart = 1'b0;
        s_d.rdData = '0;
        usTick = 1'b0;
        periodic = 1'b0;

        // Microsecond tick
        if (s_q.usCnt == 16'(CYCLES_PER_US - 1)) begin
            s_d.usCnt = '0;
            usTick = 1'b1;
        end else begin
            s_d.usCnt = s_q.usCnt + 16'h0001;
        end

        // Periodic schedule, held off in standby
        if (s_q.standby) begin
            s_d.periodCnt = '0;
        end else if (usTick) begin
            if (s_q.periodCnt >= rate_period(s_q.convCode) - TIME_W'(1)) begin
                s_d.periodCnt = '0;
                periodic = 1'b1;
            end else begin
                s_d.periodCnt = s_q.periodCnt + TIME_W'(1);
            end
        end

        // Conversion sequencer
        case (s_q.fsm)
            FSM_IDLE: begin
                if (periodic || s_q.pending) begin
                    s_d.fsm = FSM_CONV;
                    s_d.convCnt = '0;
                    s_d.convStart = 1'b1;
                    s_d.pending = 1'b0;
                end
            end
            FSM_CONV: begin
                if (usTick) begin
                    if (s_q.convCnt == TIME_W'(CONV_US - 1)) begin
                        s_d.fsm = FSM_IDLE;
                    end else begin
                        s_d.convCnt = s_q.convCnt + TIME_W'(1);
                    end
                end
            end
            default: begin
                s_d.fsm = FSM_IDLE;
            end
        endcase

        // Register writes; a one-shot here wins over the consume above
        if (bus.wr) begin
            case (bus.addr)
                ADDR_CONV_RATE, ADDR_CONV_RATE_WR: begin
                    s_d.convCode = bus.wdata[3:0];
                end
                ADDR_ONE_SHOT: begin
                    if (s_q.standby) begin
                        s_d.pending = 1'b1;
                    end
                end
                ADDR_ENH_CFG: begin
                    s_d.hrSel = bus.wdata[HRES_BIT];
                end
                ADDR_PWM_CFG: begin
                    s_d.clkSel = bus.wdata[PWM_CLK_BIT];
                end
                ADDR_PWM_DUTY: begin
                    s_d.pwmDuty = bus.wdata;
                end
                ADDR_PWM_FREQ: begin
                    s_d.pwmFreq = bus.wdata[4:0];
                end
                ADDR_RUN_CTRL: begin
                    s_d.standby = bus.wdata[STANDBY_BIT];
                end
                default: begin
                end
            endcase
        end

        // Register reads
        if (bus.rd) begin
            case (bus.addr)
                ADDR_CONV_RATE: begin
                    s_d.rdData = {4'h0, s_q.convCode};
                end
                ADDR_ENH_CFG: begin
                    s_d.rdData[HRES_BIT] = s_q.hrSel;
                end
                ADDR_PWM_CFG: begin
                    s_d.rdData[PWM_CLK_BIT] = s_q.clkSel;
                end
                ADDR_PWM_DUTY: begin
                    s_d.rdData = s_q.pwmDuty;
                end
                ADDR_PWM_FREQ: begin
                    s_d.rdData = {3'h0, s_q.pwmFreq};
                end
                ADDR_RUN_CTRL: begin
                    s_d.rdData[STANDBY_BIT] = s_q.standby;
                end
                ADDR_STATUS: begin
                    s_d.rdData[STAT_BUSY_BIT] = s_q.fsm[1];
                    s_d.rdData[STAT_PWM_BIT] = s_q.pwmOut;
                end
                ADDR_MAKER_ID: begin
                    s_d.rdData = MAKER_CODE;
                end
                ADDR_DIE_REV: begin
                    s_d.rdData = DIE_REV_CODE;
                end
                default: begin
                    s_d.rdData = '0;
                end
            endcase
        end

        // PWM mode and step source
        hires = s_q.hrSel && !s_q.clkSel && (s_q.pwmFreq == HR_FREQ_CODE);
        freqEff = (s_q.pwmFreq == 5'h00) ? 5'h01 : s_q.pwmFreq;
        if (hires) begin
            stepTick = ticks.hr;
            periodTop = HR_PERIOD_TOP;
            pwmHigh = s_q.stepCnt < s_q.pwmDuty;
        end else begin
            stepTick = s_q.clkSel ? ticks.slow : ticks.fast;
            periodTop = {2'h0, freqEff, 1'b0} - 8'h01;
            pwmHigh = s_q.stepCnt < {2'h0, s_q.pwmDuty[5:0]};
        end

        if (s_q.stepCnt > periodTop) begin
            s_d.stepCnt = '0;
        end else if (stepTick) begin
            s_d.stepCnt = (s_q.stepCnt == periodTop) ? 8'h00 : s_q.stepCnt + 8'h01;
        end
        s_d.pwmOut = pwmHigh;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
            s_q.convCode <= CONV_RATE_RST;
            s_q.pwmFreq <= PWM_FREQ_RST;
            s_q.pwmDuty <= PWM_DUTY_RST;
            s_q.fsm <= FSM_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdData = s_q.rdData;
    assign pwmOut = s_q.pwmOut;
    assign convStart = s_q.convStart;
    assign convBusy = s_q.fsm[1];

endmodule : fpc_top

`default_nettype wire

// [verif/fpc_top_sva.sv]
// Purpose: Port assertions for the fan PWM and conversion block.
// Assumes: Scaled conversion of five one-cycle ticks.
// Notes: Bound to every fpc_top.
`default_nettype none
module fpc_top_sva
    import fpc_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h5A,
    parameter logic [7:0] DIE_REV_CODE = 8'h23
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Watched ports
    input wire fpc_bus_t bus,
    input wire logic [7:0] rdData,
    input wire logic pwmOut,
    input wire logic convStart,
    input wire logic convBusy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);

    a_start_busy: assert property (convStart |-> convBusy)
        else $error("start without busy");
    a_start_pulse: assert property (convStart |=> !convStart)
        else $error("start too long");
    a_busy_cause: assert property ($rose(convBusy) |-> convStart)
        else $error("busy without start");
    a_busy_hold: assert property (convStart |=> convBusy [*3])
        else $error("busy too short");
    a_busy_end: assert property (convStart |-> ##[4:8] !convBusy)
        else $error("busy too long");
    a_rate_upper: assert property (
        $past(bus.rd) && $past(bus.addr) == ADDR_CONV_RATE |-> rdData[7:4] == 4'h0)
        else $error("rate upper bits set");
    a_maker_id: assert property (
        $past(bus.rd) && $past(bus.addr) == ADDR_MAKER_ID |-> rdData == MAKER_CODE)
        else $error("maker code wrong");
    a_rev_id: assert property (
        $past(bus.rd) && $past(bus.addr) == ADDR_DIE_REV |-> rdData == DIE_REV_CODE)
        else $error("revision code wrong");
    a_trig_wo: assert property (
        $past(bus.rd) && $past(bus.addr) == ADDR_ONE_SHOT |-> rdData == 8'h00)
        else $error("trigger reads nonzero");
endmodule : fpc_top_sva

bind fpc_top fpc_top_sva #(.MAKER_CODE(MAKER_CODE), .DIE_REV_CODE(DIE_REV_CODE)) u_sva (
    .clk(clk), .reset(reset), .bus(bus), .rdData(rdData), .pwmOut(pwmOut),
    .convStart(convStart), .convBusy(convBusy));
`default_nettype wire

// [verif/fpc_fan_model.sv]
// Purpose: Fan that integrates its drive on-time.
// Assumes: Drive sampled on clk.
// Notes: Clear restarts the tally.
`default_nettype none
module fpc_fan_model (
    // Clock and drive
    input wire logic clk,
    input wire logic pwmOut,
    // Tally
    input wire logic clear,
    output int onCycles
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge clk) begin
        onCycles <= clear ? 0 : onCycles + int'(pwmOut === 1'b1);
    end
endmodule : fpc_fan_model
`default_nettype wire

// [verif/tb_top.sv]
// Purpose: Self-checking bench for the fan PWM and conversion block.
// Assumes: Scaled timing: one cycle per microsecond, high-resolution tick every cycle.
// Notes: Duty is judged by fan on-time over two whole periods.
`default_nettype none
module tb_top
    import fpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic clear = 1'b0;
    bit hr = 1'b0;
    fpc_bus_t bus = '0;
    logic [7:0] rdData;
    logic pwmOut;
    logic convStart;
    logic convBusy;
    int onCycles;
    int fails = 0;
    int num_checks = 0;
    int starts = 0;
    int busyCyc = 0;

    always #4 clk = ~clk;
    always @(posedge clk) starts <= starts + int'(convStart === 1'b1);
    always @(posedge clk) busyCyc <= busyCyc + int'(convBusy === 1'b1);

    fpc_top #(.CYCLES_PER_US(1), .PERIOD_DIV(1000), .CONV_US(5), .TICK_DIV(1)) u_fpc_top (
        .clk(clk), .reset(reset), .bus(bus), .rdData(rdData), .pwmOut(pwmOut),
        .convStart(convStart), .convBusy(convBusy));
    fpc_fan_model u_fpc_fan_model (
        .clk(clk), .pwmOut(pwmOut), .clear(clear), .onCycles(onCycles));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic drive(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: w, rd: r};
    endtask : drive

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        drive(a, d, 1'b1, 1'b0);
        drive(8'h00, 8'h00, 1'b0, 1'b0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        drive(a, 8'h00, 1'b0, 1'b1);
        drive(8'h00, 8'h00, 1'b0, 1'b0);
        #1 check(rdData, exp);
    endtask : rd

    // Interval between two conversions, within two cycles
    task automatic gap(input logic [7:0] code, input int exp);
        int s;
        int n;
        wr(ADDR_CONV_RATE, code);
        s = starts;
        n = 0;
        for (int i = 0; i < 40000 && starts < s + 2; i++) begin
            @(posedge clk);
            n += int'(starts == s + 1);
        end
        if (starts < s + 2) begin
            check(starts - s, 2);
            final_report();
        end else begin
            check((n >= exp - 2 && n <= exp + 2) ? exp : n, exp);
        end
    endtask : gap

    task automatic duty(input logic [7:0] f, input logic [7:0] d, input int step);
        int n;
        int per;
        int hi;
        n = (f == 8'h00) ? 1 : int'(f);
        per = hr ? 255 : 2 * n * step;
        hi = hr ? int'(d) : ((int'(d[5:0]) < 2 * n) ? int'(d[5:0]) : 2 * n) * step;
        wr(ADDR_PWM_FREQ, f);
        wr(ADDR_PWM_DUTY, d);
        cyc(2 * per + 4200);
        @(posedge clk) clear <= 1'b1;
        @(posedge clk) clear <= 1'b0;
        cyc(2 * per);
        #1 check(onCycles, 2 * hi);
    endtask : duty

    task automatic final_report();
        if (fails == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    initial begin
        int s;
        int b;
        void'($urandom(20678));
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        rd(ADDR_CONV_RATE, 8'h08);
        rd(ADDR_MAKER_ID, 8'h5A);
        wr(ADDR_DIE_REV, 8'h00);
        rd(ADDR_DIE_REV, 8'h23);
        rd(ADDR_ONE_SHOT, 8'h00);
        rd(8'h77, 8'h00);
        wr(ADDR_CONV_RATE, 8'hA5);
        rd(ADDR_CONV_RATE, 8'h05);
        wr(ADDR_CONV_RATE_WR, 8'hF9);
        rd(ADDR_CONV_RATE, 8'h09);
        for (int c = 7; c < 10; c++) begin
            gap(c[7:0], RATE_PERIOD_US[c] / 1000);
        end
        gap(8'(10 + $urandom % 6), RATE_PERIOD_US[9] / 1000);
        wr(ADDR_RUN_CTRL, 8'h01);
        cyc(12);
        s = starts;
        b = busyCyc;
        repeat (3) begin
            wr(ADDR_ONE_SHOT, 8'($urandom));
            cyc(12);
        end
        check(starts - s, 3);
        check(busyCyc - b, 3 * 5);
        wr(ADDR_RUN_CTRL, 8'h00);
        wr(ADDR_ENH_CFG, 8'h10);
        hr = 1'b1;
        duty(8'h08, 8'hBF, 16);
        duty(8'h08, 8'hFF, 16);
        wr(ADDR_ENH_CFG, 8'h00);
        hr = 1'b0;
        duty(8'h08, 8'h08, 16);
        duty(8'h00, 8'h01, 16);
        duty(8'h02, 8'h3F, 16);
        repeat (3) duty(8'($urandom % 32), 8'($urandom), 16);
        wr(ADDR_PWM_CFG, 8'h08);
        duty(8'h01, 8'h01, 4096);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
